// File: hw/hts_readout_regs.sv
`timescale 1ns/1ns

// Operation
// [R1] Each readout word holds measured data, a valid flag and a checksum.
// [R2] Checksum in bits 23:17, valid at bit 16, data in bits 15:0.
// [R3] Checksum is CRC-7, generator 0x89, over valid flag plus 16 data bits.
// [R4] Checksum division starts from all ones, 0x7F.
// [R5] Initial value appended below payload, divided MSB first, 7-bit remainder kept.
// [R6] Starting a measurement clears that sensor's valid flag, in either run mode.
// [R7] Completion stores data, sets valid and stores checksum.
// [R8] Continuous repeats start without clearing valid.
// [R9] Data is an unsigned 16-bit fixed-point value scaled per sensor.
// [R10] Temperature data counts 1/64 kelvin.
// [R11] Humidity data counts 1/512 percent.
// [R12] Reading a word's lowest byte copies the whole word into a shadow first.
// [R13] Higher bytes of a readout word are read only from the shadow.
// [R14] Little endian words: temperature at 0x30-0x32, humidity at 0x33-0x35.
// [R15] Register map decode: identity, control, status, run, start, stop, flags.
// [R16] Part code, die revision and serial read as zero unless active.
// [R17] Host reads identity by clearing low power and polling the active flag.
// [R18] Or host piggybacks on a measurement and rechecks the active flag after.
// [R19] Start bit 0 is temperature, bit 1 humidity; 0x03 starts both.
// [R20] Address byte loads the pointer; each data byte moves it up by one.
// [R21] Writes to reserved or read-only addresses are refused; reserved reads give zero.
// [R22] System status bit 0 is one only while active.
// [R23] System control bit 0 enables automatic standby; resets to one.
// [R24] Data, valid flag and checksum are written in the same cycle.
module hts_readout_regs #(
  parameter int          BOOT_CYCLES   = 16,                     // Standby to active delay
  parameter logic [15:0] PART_CODE     = 16'h5A5A,               // Arbitrary value
  parameter logic [15:0] DIE_REVISION  = 16'h0003,               // Arbitrary value
  parameter logic [63:0] UNIQUE_SERIAL = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
  input  wire logic                                            sys_clk,     // System clock
  input  wire logic                                            rst_n,       // Async reset, low
  input  wire logic                                            ptr_load,    // Address byte strobe
  input  wire logic [7:0]                                      ptr_byte,    // Address byte
  input  wire logic                                            wr_stb,      // Data byte write strobe
  input  wire logic [7:0]                                      wr_byte,     // Data byte written
  input  wire logic                                            rd_stb,      // Data byte read strobe
  input  wire hts_pkg::hts_result_type [hts_pkg::NUM_SENSORS-1:0] sens_result, // Sensor completions
  output logic      [7:0]                                      rd_byte,     // Byte read
  output logic                                                 rd_done,     // Read answer pulse
  output logic                                                 wr_done,     // Write answer pulse
  output logic                                                 wr_ack,      // Write acknowledged
  output logic      [hts_pkg::NUM_SENSORS-1:0]                 meas_go,     // Launch pulse per sensor
  output logic                                                 active_state_flag   // Active state flag
);

  localparam int NS = hts_pkg::NUM_SENSORS;
  localparam logic [7:0] READOUT_ADDR [NS] = '{hts_pkg::ADDR_TEMP_READOUT, hts_pkg::ADDR_HUM_READOUT};

  if (BOOT_CYCLES < 1 || BOOT_CYCLES > 65535) begin : g_chk_boot
    $error("BOOT_CYCLES must be 1 to 65535");
  end

  // Flags, start and stop carry one bit per sensor in the low bits of a byte
  if (NS != 2) begin : g_chk_sensors
    $error("NUM_SENSORS must be 2");
  end

  // Identity bytes, part code first, each little endian
  wire logic [95:0] id_bytes = {UNIQUE_SERIAL, DIE_REVISION, PART_CODE};

  // Register bus group
  logic [7:0]              ptr_ff, nxt_ptr;
  logic [7:0]              rd_byte_ff, nxt_rd_byte;
  logic                    rd_done_ff, nxt_rd_done;
  logic                    wr_done_ff, nxt_wr_done;
  logic                    wr_ack_ff, nxt_wr_ack;
  logic [7:0]              system_control_ff, nxt_system_control;
  logic [7:0]              run_mode_ff, nxt_run_mode;
  hts_pkg::hts_readout_type shadow_ff [NS];
  hts_pkg::hts_readout_type nxt_shadow [NS];
  logic [NS-1:0]           wr_start;
  logic [NS-1:0]           wr_stop;

  // Sequencer group
  hts_pkg::hts_sys_state_type state_ff, nxt_state;
  logic [15:0]             boot_cnt_ff, nxt_boot_cnt;
  logic [NS-1:0]           start_req_ff, nxt_start_req;
  logic [NS-1:0]           stop_req_ff, nxt_stop_req;
  logic [NS-1:0]           cont_ff, nxt_cont;
  logic [NS-1:0]           meas_ff, nxt_meas;
  logic [NS-1:0]           meas_go_ff, nxt_meas_go;
  logic                    active_state_flag_ff, nxt_active_state_flag;
  logic [NS-1:0]           fresh;
  logic [NS-1:0]           done_mask;
  logic [NS-1:0]           want;
  logic                    idle;

  // Measurement storage
  hts_pkg::hts_readout_type readout_ff [NS];

  always_comb begin : bus_next
    logic [7:0] rd_val;
    rd_val       = 8'h00;                                        // [R21]
    nxt_ptr      = ptr_ff;
    nxt_rd_byte  = rd_byte_ff;
    nxt_rd_done  = 1'b0;
    nxt_wr_done  = 1'b0;
    nxt_wr_ack   = 1'b0;
    nxt_system_control = system_control_ff;
    nxt_run_mode = run_mode_ff;
    nxt_shadow   = shadow_ff;
    wr_start     = '0;
    wr_stop      = '0;
    if (ptr_load) begin
      nxt_ptr = ptr_byte;                                        // [R20]
    end else if (wr_stb) begin
      nxt_wr_done = 1'b1;
      nxt_ptr     = ptr_ff + hts_pkg::ADDR_STEP;                 // [R20]
      case (ptr_ff)                                              // [R15]
        hts_pkg::ADDR_SYS_CONTROL: begin
          nxt_wr_ack   = 1'b1;
          nxt_system_control = wr_byte & hts_pkg::SYS_CONTROL_WMASK;   // [R23]
        end
        hts_pkg::ADDR_RUN_MODE: begin
          nxt_wr_ack   = 1'b1;
          nxt_run_mode = wr_byte;
        end
        hts_pkg::ADDR_MEAS_START: begin
          nxt_wr_ack = 1'b1;
          wr_start   = wr_byte[NS-1:0];                          // [R19]
        end
        hts_pkg::ADDR_MEAS_STOP: begin
          nxt_wr_ack = 1'b1;
          wr_stop    = wr_byte[NS-1:0];
        end
        default: begin
          nxt_wr_ack = 1'b0;                                     // [R21]
        end
      endcase
    end else if (rd_stb) begin
      nxt_rd_done = 1'b1;
      nxt_ptr     = ptr_ff + hts_pkg::ADDR_STEP;                 // [R20]
      // Identity stays hidden while booting, so hosts poll the active flag first
      if (ptr_ff <= hts_pkg::ADDR_ID_LAST) begin
        if (state_ff == hts_pkg::SYS_AWAKE) begin
          rd_val = id_bytes[{ptr_ff[3:0], 3'b000} +: 8];         // [R16]
        end
      end else begin
        case (ptr_ff)                                            // [R15]
          hts_pkg::ADDR_SYS_CONTROL: rd_val = system_control_ff;
          hts_pkg::ADDR_SYS_STATUS:  rd_val = {7'h00, state_ff == hts_pkg::SYS_AWAKE}; // [R22]
          hts_pkg::ADDR_RUN_MODE:    rd_val = run_mode_ff;
          hts_pkg::ADDR_MEAS_FLAGS:  rd_val = {6'h00, meas_ff};
          default:                   rd_val = 8'h00;             // [R21]
        endcase
        // Only a lowest-byte read refreshes the shadow; a burst begun mid-word sees an older copy
        for (int s = 0; s < NS; s++) begin
          if (ptr_ff == READOUT_ADDR[s]) begin
            nxt_shadow[s] = readout_ff[s];                       // [R12]
            rd_val        = readout_ff[s][7:0];                  // [R14]
          end else if (ptr_ff == READOUT_ADDR[s] + 8'h01) begin
            rd_val = shadow_ff[s][15:8];                         // [R13]
          end else if (ptr_ff == READOUT_ADDR[s] + 8'h02) begin
            rd_val = shadow_ff[s][23:16];                        // [R13]
          end
        end
      end
      nxt_rd_byte = rd_val;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff      <= 8'h00;
      rd_byte_ff  <= 8'h00;
      rd_done_ff  <= 1'b0;
      wr_done_ff  <= 1'b0;
      wr_ack_ff   <= 1'b0;
      system_control_ff <= hts_pkg::SYS_CONTROL_RESET;                 // [R23]
      run_mode_ff <= hts_pkg::RUN_MODE_RESET;
      for (int s = 0; s < NS; s++) begin
        shadow_ff[s] <= hts_pkg::READOUT_RESET;
      end
    end else begin
      ptr_ff      <= nxt_ptr;
      rd_byte_ff  <= nxt_rd_byte;
      rd_done_ff  <= nxt_rd_done;
      wr_done_ff  <= nxt_wr_done;
      wr_ack_ff   <= nxt_wr_ack;
      system_control_ff <= nxt_system_control;
      run_mode_ff <= nxt_run_mode;
      shadow_ff   <= nxt_shadow;
    end
  end

  // Steps: sensors launch together and the next step is chosen only when all are done
  always_comb begin : seq_next
    idle           = (meas_ff == '0);
    want           = start_req_ff | cont_ff;
    nxt_state      = state_ff;
    nxt_boot_cnt   = boot_cnt_ff;
    nxt_cont       = cont_ff;
    nxt_meas_go    = '0;
    fresh          = '0;
    nxt_meas       = meas_ff & ~done_mask;
    // Start writes during a step are dropped, stop writes are held to the step's end
    nxt_start_req  = start_req_ff | (idle ? wr_start : '0);     // [R19]
    nxt_stop_req   = stop_req_ff | wr_stop;
    // Start and stop in one step: the launch runs, then the stop ends continuous mode
    if (!idle && nxt_meas == '0) begin
      nxt_cont     = cont_ff & ~(stop_req_ff | wr_stop) & run_mode_ff[NS-1:0];
      nxt_stop_req = '0;
    end
    unique case (state_ff)
      hts_pkg::SYS_STANDBY: begin
        if (want != '0 || !system_control_ff[hts_pkg::LOW_POWER_BIT]) begin // [R23]
          nxt_state    = hts_pkg::SYS_BOOTING;
          nxt_boot_cnt = 16'(BOOT_CYCLES - 1);
        end
      end
      hts_pkg::SYS_BOOTING: begin
        if (boot_cnt_ff == 16'h0000) begin
          nxt_state = hts_pkg::SYS_AWAKE;
        end else begin
          nxt_boot_cnt = boot_cnt_ff - 16'h0001;
        end
      end
      hts_pkg::SYS_AWAKE: begin
        if (idle) begin
          if (want != '0) begin
            nxt_meas      = want;
            nxt_meas_go   = want;
            fresh         = start_req_ff;                        // [R6] [R8]
            nxt_cont      = cont_ff | (start_req_ff & run_mode_ff[NS-1:0]);
            nxt_start_req = '0;
          end else if (system_control_ff[hts_pkg::LOW_POWER_BIT]) begin
            nxt_state = hts_pkg::SYS_STANDBY;                    // [R23]
          end
        end
      end
      // Unused state code falls back to standby rather than locking up
      default: begin
        nxt_state = hts_pkg::SYS_STANDBY;
      end
    endcase
    // Registered from the next state so the pin and the status bit agree every cycle
    nxt_active_state_flag = (nxt_state == hts_pkg::SYS_AWAKE);          // [R22]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= hts_pkg::SYS_STANDBY;
      boot_cnt_ff   <= 16'h0000;
      start_req_ff  <= '0;
      stop_req_ff   <= '0;
      cont_ff       <= '0;
      meas_ff       <= '0;
      meas_go_ff    <= '0;
      active_state_flag_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      boot_cnt_ff   <= nxt_boot_cnt;
      start_req_ff  <= nxt_start_req;
      stop_req_ff   <= nxt_stop_req;
      cont_ff       <= nxt_cont;
      meas_ff       <= nxt_meas;
      meas_go_ff    <= nxt_meas_go;
      active_state_flag_ff <= nxt_active_state_flag;
    end
  end

  // Per-sensor readout word; data scaling (1/64 K, 1/512 %RH) is the sensor's, passed unchanged
  for (genvar s = 0; s < NS; s++) begin : g_sensor
    hts_pkg::hts_readout_type nxt_readout;

    // A completion only counts while that sensor is measuring
    assign done_mask[s] = meas_ff[s] & sens_result[s].done;

    always_comb begin
      nxt_readout = readout_ff[s];
      if (done_mask[s]) begin
        nxt_readout.data  = sens_result[s].data;                 // [R7] [R9] [R10] [R11]
        nxt_readout.valid = 1'b1;                                // [R7]
        nxt_readout.crc   = hts_pkg::hts_crc7({1'b1, sens_result[s].data}); // [R3] [R4] [R5] [R24]
      end else if (fresh[s]) begin
        // Checksum follows the cleared flag so the word stays self-consistent
        nxt_readout.valid = 1'b0;                                // [R6]
        nxt_readout.crc   = hts_pkg::hts_crc7({1'b0, readout_ff[s].data}); // [R24]
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        readout_ff[s] <= hts_pkg::READOUT_RESET;                 // [R1] [R2]
      end else begin
        readout_ff[s] <= nxt_readout;
      end
    end
  end

  assign rd_byte    = rd_byte_ff;
  assign rd_done    = rd_done_ff;
  assign wr_done    = wr_done_ff;
  assign wr_ack     = wr_ack_ff;
  assign meas_go    = meas_go_ff;
  assign active_state_flag = active_state_flag_ff;

endmodule // hts_readout_regs

// File: pkg/hts_pkg.sv
package hts_pkg;

  // Byte addresses of the register map
  localparam logic [7:0] ADDR_PART_CODE    = 8'h00;
  localparam logic [7:0] ADDR_DIE_REVISION = 8'h02;
  localparam logic [7:0] ADDR_UNIQUE_SERIAL = 8'h04;
  localparam logic [7:0] ADDR_ID_LAST      = 8'h0B;
  localparam logic [7:0] ADDR_SYS_CONTROL  = 8'h10;
  localparam logic [7:0] ADDR_SYS_STATUS   = 8'h11;
  localparam logic [7:0] ADDR_RUN_MODE     = 8'h21;
  localparam logic [7:0] ADDR_MEAS_START   = 8'h22;
  localparam logic [7:0] ADDR_MEAS_STOP    = 8'h23;
  localparam logic [7:0] ADDR_MEAS_FLAGS   = 8'h24;
  localparam logic [7:0] ADDR_TEMP_READOUT = 8'h30;
  localparam logic [7:0] ADDR_HUM_READOUT  = 8'h33;
  localparam logic [7:0] ADDR_STEP         = 8'h01;

  // Sensor indices and bit positions in run mode, start, stop and flags
  localparam int NUM_SENSORS = 2;
  localparam int SENS_TEMP   = 0;
  localparam int SENS_HUM    = 1;

  // Readout word layout
  localparam int DATA_LSB      = 0;
  localparam int DATA_WIDTH    = 16;
  localparam int VALID_BIT     = 16;
  localparam int CRC_LSB       = 17;
  localparam int CRC_WIDTH     = 7;
  localparam int PAYLOAD_WIDTH = 17;
  localparam int WORD_WIDTH    = 24;

  // Checksum generator x^7 + x^3 + 1 and start value
  localparam logic [7:0] CRC_POLY = 8'h89;
  localparam logic [6:0] CRC_INIT = 7'h7F;

  // Data scaling: counts per kelvin and per percent relative humidity
  localparam int TEMP_COUNTS_PER_KELVIN  = 64;
  localparam int HUM_COUNTS_PER_PERCENT  = 512;

  // Control and status fields
  localparam int         LOW_POWER_BIT     = 0;
  localparam int         ACTIVE_BIT        = 0;
  localparam logic [7:0] SYS_CONTROL_RESET = 8'h01;
  localparam logic [7:0] SYS_CONTROL_WMASK = 8'h7F;
  localparam logic [7:0] RUN_MODE_RESET    = 8'h00;

  typedef struct packed {
    logic [CRC_WIDTH-1:0]  crc;
    logic                  valid;
    logic [DATA_WIDTH-1:0] data;
  } hts_readout_type;

  typedef struct packed {
    logic                  done;
    logic [DATA_WIDTH-1:0] data;
  } hts_result_type;

  typedef enum logic [1:0] {SYS_STANDBY, SYS_BOOTING, SYS_AWAKE} hts_sys_state_type;

  // MSB-first long division of {payload, init} by the aligned generator
  function automatic logic [CRC_WIDTH-1:0] hts_crc7(input logic [PAYLOAD_WIDTH-1:0] payload);
    logic [WORD_WIDTH-1:0] work;
    work = {payload, CRC_INIT};
    for (int i = WORD_WIDTH - 1; i >= CRC_WIDTH; i--) begin
      if (work[i]) begin
        work = work ^ (WORD_WIDTH'(CRC_POLY) << (i - CRC_WIDTH));
      end
    end
    return work[CRC_WIDTH-1:0];
  endfunction

  localparam hts_readout_type READOUT_RESET = '{crc: hts_crc7(17'h00000), valid: 1'b0, data: 16'h0000};

endpackage

// File: bench/hts_readout_regs_properties.sv
`timescale 1ns/1ns
module hts_readout_regs_properties (
  input wire logic                                               sys_clk,     // Clock
  input wire logic                                               rst_n,       // Reset, low
  input wire logic                                               ptr_load,    // Address strobe
  input wire logic [7:0]                                         ptr_byte,    // Address byte
  input wire logic                                               wr_stb,      // Write strobe
  input wire logic [7:0]                                         wr_byte,     // Write data
  input wire logic                                               rd_stb,      // Read strobe
  input wire hts_pkg::hts_result_type [hts_pkg::NUM_SENSORS-1:0] sens_result, // Completions
  input wire logic [7:0]                                         rd_byte,     // Read data
  input wire logic                                               rd_done,     // Read answer
  input wire logic                                               wr_done,     // Write answer
  input wire logic                                               wr_ack,      // Write ack
  input wire logic [hts_pkg::NUM_SENSORS-1:0]                    meas_go,     // Launch
  input wire logic                                               active_state_flag   // Active flag
);
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic       rd_take;
  logic       wr_take;
  logic       rsv;
  logic       wable;
  assign rd_take = rd_stb && !ptr_load && !wr_stb;
  assign wr_take = wr_stb && !ptr_load;
  assign rsv = !(ptr_ff inside {[8'h00:8'h0B], 8'h10, 8'h11, 8'h21, 8'h24, [8'h30:8'h35]});
  assign wable = ptr_ff inside {8'h10, [8'h21:8'h23]};
  // Shadow pointer so address-dependent answers can be judged at the ports
  always_comb begin
    nxt_ptr = ptr_load ? ptr_byte : (wr_stb || rd_stb) ? ptr_ff + 8'h01 : ptr_ff;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ptr_ff <= 8'h00;
    else ptr_ff <= nxt_ptr;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (rd_done == $past(rd_take))
    else $error("read answer timing wrong");
  a_write_answer: assert property (wr_take |=> wr_done && wr_ack == $past(wable))
    else $error("write answer or ack wrong");
  a_ack_alone: assert property (!wr_done |-> !wr_ack)
    else $error("ack without write answer");
  a_reserved_zero: assert property (rd_take && rsv |=> rd_byte == 8'h00)
    else $error("reserved read not zero");
  a_id_gated: assert property (rd_take && ptr_ff <= 8'h0B && !active_state_flag |=> rd_byte == 8'h00)
    else $error("identity readable outside active");
  a_status_bit: assert property (rd_take && ptr_ff == 8'h11 |=> rd_byte == {7'h00, $past(active_state_flag)})
    else $error("status byte wrong");
  a_go_active: assert property (|meas_go |-> active_state_flag)
    else $error("launch outside active state");
  a_byte_hold: assert property (!rd_done |-> $stable(rd_byte))
    else $error("read byte changed without answer");
  c_temp_read: cover property (rd_take && ptr_ff == 8'h30);
  c_both_go: cover property (meas_go == 2'b11);
  c_nack: cover property (wr_take && !wable);
endmodule // hts_readout_regs_properties

// File: bench/hts_sensor_model.sv
`timescale 1ns/1ns
module hts_sensor_model #(
  parameter int DELAY = 30 // Conversion cycles, 2..255
) (
  input  wire logic                   sys_clk,    // Clock
  input  wire logic                   rst_n,      // Reset, low
  input  wire logic [1:0]             meas_go,    // Launch per sensor
  input  wire logic [15:0]            tdata,      // Temperature result
  input  wire logic [15:0]            hdata,      // Humidity result
  output hts_pkg::hts_result_type [1:0] sens_result // Completions
);
  logic [1:0][7:0] cnt_ff;
  logic [1:0][7:0] nxt_cnt;
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      nxt_cnt[s] = meas_go[s] ? 8'(DELAY) : (cnt_ff[s] != 8'h00) ? cnt_ff[s] - 8'h01 : 8'h00;
      sens_result[s].done = (cnt_ff[s] == 8'h01);
    end
    // Index 0 temperature, 1 humidity; data is garbage outside the done cycle
    sens_result[0].data = sens_result[0].done ? tdata : ~tdata;
    sens_result[1].data = sens_result[1].done ? hdata : ~hdata;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= '0;
    else cnt_ff <= nxt_cnt;
  end
endmodule // hts_sensor_model

// File: bench/humidity_temp_readout_regs_test.sv
`timescale 1ns/1ns
module humidity_temp_readout_regs_test;
  localparam logic [15:0] PCODE = 16'hC3C3;                // Arbitrary value
  localparam logic [15:0] DREV  = 16'h0007;                // Arbitrary value
  localparam logic [63:0] SER   = 64'h1122_3344_5566_7788; // Arbitrary value
  logic                            sys_clk  = 1'b0;
  logic                            rst_n    = 1'b0;
  logic                            ptr_load = 1'b0;
  logic                            wr_stb   = 1'b0;
  logic                            rd_stb   = 1'b0;
  logic [7:0]                      ptr_byte = 8'h00;
  logic [7:0]                      wr_byte  = 8'h00;
  logic [15:0]                     tdata    = 16'h49FD;
  logic [15:0]                     hdata    = 16'h2E6C;
  hts_pkg::hts_result_type [1:0]   sens_result;
  logic [7:0]                      rd_byte;
  logic                            rd_done, wr_done, wr_ack, active_state_flag;
  logic [1:0]                      meas_go;
  logic [63:0]                     v;
  int                              err_total = 0;
  int                              checks_done = 0;
  always #10 sys_clk = ~sys_clk;
  hts_readout_regs #(.BOOT_CYCLES(2), .PART_CODE(PCODE), .DIE_REVISION(DREV), .UNIQUE_SERIAL(SER))
    hts_readout_regs_i (.sys_clk, .rst_n, .ptr_load, .ptr_byte, .wr_stb, .wr_byte, .rd_stb, .sens_result,
                        .rd_byte, .rd_done, .wr_done, .wr_ack, .meas_go, .active_state_flag);
  hts_sensor_model #(.DELAY(30)) hts_sensor_model_i (.sys_clk, .rst_n, .meas_go, .tdata, .hdata, .sens_result);
  task end_sim;
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task setp(input logic [7:0] a);
    @(negedge sys_clk);
    ptr_load = 1'b1;
    ptr_byte = a;
    @(negedge sys_clk);
    ptr_load = 1'b0;
  endtask
  // Back-to-back burst, one byte answered each cycle
  task rdn(input logic [7:0] a, input int n);
    setp(a);
    v = 64'h0;
    rd_stb = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      if (i == n - 1) rd_stb = 1'b0;
      chk(rd_done, 1'b1);
      v[8*i+:8] = rd_byte;
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d, input logic ack);
    setp(a);
    wr_stb = 1'b1;
    wr_byte = d;
    @(negedge sys_clk);
    wr_stb = 1'b0;
    chk(wr_done, 1'b1);
    chk(wr_ack, ack);
  endtask
  task poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    for (int i = 0; i < 300; i++) begin
      rdn(a, 1);
      if ((v[7:0] & m) == e) return;
    end
    chk(v[7:0] & m, e);
    end_sim;
  endtask
  task waitdone;
    for (int i = 0; i < 200; i++) begin
      @(negedge sys_clk);
      if (sens_result[0].done === 1'b1) return;
    end
    chk(64'h0, 64'h1);
    end_sim;
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    rdn(8'h10, 3); chk(v, 64'h01);
    rdn(8'h20, 5); chk(v, 64'h0);
    rdn(8'h00, 8); chk(v, 64'h0);
    wreg(8'h11, 8'hFF, 1'b0);
    wreg(8'h24, 8'hFF, 1'b0);
    wreg(8'h30, 8'hFF, 1'b0);
    wreg(8'h00, 8'hFF, 1'b0);
    wreg(8'h40, 8'hFF, 1'b0);
    // Identity through the dedicated path: low power off, wait active
    wreg(8'h10, 8'h00, 1'b1);
    poll(8'h11, 8'h01, 8'h01);
    chk(active_state_flag, 1'b1);
    rdn(8'h00, 4); chk(v, {32'h0, DREV, PCODE});
    rdn(8'h04, 8); chk(v, SER);
    wreg(8'h10, 8'h01, 1'b1);
    poll(8'h11, 8'h01, 8'h00);
    wreg(8'h22, 8'h03, 1'b1);
    // Identity while a measurement keeps the device awake
    poll(8'h11, 8'h01, 8'h01);
    rdn(8'h00, 2);
    chk(v, {48'h0, PCODE});
    rdn(8'h11, 1);
    chk(v, 64'h01);
    poll(8'h24, 8'h03, 8'h03);
    poll(8'h24, 8'h03, 8'h00);
    rdn(8'h30, 6); chk(v, 64'hF52E6C0B49FD);
    tdata = 16'h1234;
    wreg(8'h22, 8'h01, 1'b1);
    poll(8'h24, 8'h01, 8'h01);
    rdn(8'h30, 1); chk(v, 64'hFD);
    poll(8'h24, 8'h01, 8'h00);
    rdn(8'h31, 2); chk(v[8:0], 9'h049);
    rdn(8'h30, 3); chk(v[16:0], 17'h11234);
    // Continuous: valid must survive the relaunch
    wreg(8'h21, 8'h01, 1'b1);
    wreg(8'h22, 8'h01, 1'b1);
    waitdone;
    waitdone;
    rdn(8'h30, 3); chk(v[16], 1'b1);
    rdn(8'h24, 1); chk(v[0], 1'b1);
    wreg(8'h23, 8'h01, 1'b1);
    poll(8'h24, 8'h01, 8'h00);
    poll(8'h11, 8'h01, 8'h00);
    chk(active_state_flag, 1'b0);
    end_sim;
  end
endmodule // humidity_temp_readout_regs_test
bind hts_readout_regs hts_readout_regs_properties hts_readout_regs_properties_i (
  .sys_clk, .rst_n, .ptr_load, .ptr_byte, .wr_stb, .wr_byte, .rd_stb, .sens_result,
  .rd_byte, .rd_done, .wr_done, .wr_ack, .meas_go, .active_state_flag);
